//--- hdl/elc_pkg.sv
// Constants for the external line event controller: register map,
// field widths, reset values and core vector numbers.
// Assumes a 32-bit register port clocked by the system bus clock.
package elc_pkg;
  localparam int ELC_LINES = 10;
  localparam int ELC_PIN_LINES = 8;
  localparam int ELC_LINE_SUPPLY = 8;
  localparam int ELC_LINE_WAKE = 9;
  localparam int ELC_PORTS = 3;
  localparam int ELC_AW = 8;
  localparam int ELC_DW = 32;
  // Register byte offsets
  localparam logic [7:0] ELC_OFS_IRQ_EN = 8'h00;
  localparam logic [7:0] ELC_OFS_EVT_EN = 8'h04;
  localparam logic [7:0] ELC_OFS_RISE = 8'h08;
  localparam logic [7:0] ELC_OFS_FALL = 8'h0C;
  localparam logic [7:0] ELC_OFS_SWTRIG = 8'h10;
  localparam logic [7:0] ELC_OFS_PEND = 8'h14;
  localparam logic [7:0] ELC_OFS_PORTSEL = 8'h18;
  localparam logic [7:0] ELC_OFS_CORE = 8'h1C;
  // Reset values
  localparam logic [9:0] ELC_RST_LINES = 10'h000;
  localparam logic [15:0] ELC_RST_PORTSEL = 16'h0000;
  localparam logic [2:0] ELC_RST_CORE = 3'h0;
  // Core control register field positions
  localparam int ELC_CORE_SEND_EVENT_ON_PENDING_BIT = 0;
  localparam int ELC_CORE_MASK_LOW_BIT = 1;
  localparam int ELC_CORE_MASK_SUP_BIT = 2;
  // Core vector numbers and entry addresses
  localparam logic [7:0] ELC_VEC_LOW_LINES = 8'h14;
  localparam logic [31:0] ELC_ENTRY_LOW_LINES = 32'h00000050;
  localparam logic [7:0] ELC_VEC_SUPPLY = 8'h11;
  localparam logic [31:0] ELC_ENTRY_SUPPLY = 32'h00000044;
  // Synchroniser depth for pin inputs
  localparam int ELC_SYNC_STAGES = 3;
endpackage

//--- hdl/elc_sync_edge.sv
// Three-stage synchroniser with edge detection for one line.
// Assumes the input is asynchronous to CLK.
`timescale 1ns/1ps
module elc_sync_edge
  import elc_pkg::*;
#(
  // Flip-flops in the chain; the last two are compared
  parameter int STAGES = ELC_SYNC_STAGES
)
(
  // Clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // Line and edge selects
  input wire logic line_in,
  input wire logic rise_en,
  input wire logic fall_en,
  // Detected edge pulse
  output logic edge_hit
);
  logic [STAGES-1:0] sync_r;
  logic level_r;
  wire logic settled = (sync_r[STAGES-2] == sync_r[STAGES-1]);
  wire logic rise_seen;
  wire logic fall_seen;

  // Refuse a chain too short to settle before the compare
  if (STAGES < 3)
  begin : g_bad_stages
    $error("elc_sync_edge needs at least three stages");
  end

  // Shift chain into the clock domain
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      sync_r <= '0;
    else
      sync_r <= {sync_r[STAGES-2:0], line_in};
  end

  // Settled level, taken only when the last two stages agree
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      level_r <= 1'b0;
    else if (settled)
      level_r <= sync_r[STAGES-1];
  end

  // An edge counts once, when the settled level changes
  assign rise_seen = settled & sync_r[STAGES-1] & ~level_r;
  assign fall_seen = settled & ~sync_r[STAGES-1] & level_r;
  assign edge_hit = (rise_seen & rise_en) | (fall_seen & fall_en);
endmodule

//--- hdl/elc_top.sv
// External line event controller: ten edge-detected lines gated into
// interrupt requests and wake-up events, with a simple register port.
// Assumes pins are asynchronous and the register master is on CLK.
//
// How it works
// - Each line has a hardware input through an edge detector and a software trigger.
// - Edge or software trigger is gated separately by interrupt and event enables.
// - Eight control and status registers reached only through the register port.
// - A selected edge on an enabled line sets pending and requests an interrupt.
// - Writing one to a pending bit clears it; zero leaves it.
// - Rising and falling selects are independent; both give either edge.
// - Software trigger acts exactly like a hardware edge, under the same enables.
// - Enabled here but masked in core with send-on-pending gives a wake event.
// - Event-enabled line wakes the core without leaving any pending flag.
// - Lines zero to seven each pick pin n from one of three ports.
// - Line eight is the supply monitor, line nine the auto-wakeup timer.
// - Lines zero to seven merge into one request at vector 20.
// - Supply monitor line requests the core at vector 17.
// - Interrupt enable register holds bits 9 to 0, reset zero.
// - Event enable register holds bits 9 to 0, reset zero.
//
// Local design decisions: the register addresses and the address-and-strobe port.
`timescale 1ns/1ps
module elc_top
  import elc_pkg::*;
#(
  // Depth of the pin synchronisers; three is the least that settles
  parameter int SYNC_STAGES = ELC_SYNC_STAGES
)
(
  // Clock and reset
  input wire logic CLK,
  input wire logic ARST_N,
  // Register port
  input wire logic [ELC_AW-1:0] REG_ADDR,
  input wire logic [ELC_DW-1:0] REG_WDATA,
  input wire logic REG_WR,
  input wire logic REG_RD,
  output logic [ELC_DW-1:0] REG_RDATA,
  // Port pins 0..7 of three ports
  input wire logic [ELC_PIN_LINES-1:0] PORT_A_PINS,
  input wire logic [ELC_PIN_LINES-1:0] PORT_C_PINS,
  input wire logic [ELC_PIN_LINES-1:0] PORT_D_PINS,
  // Supply monitor and auto-wakeup events
  input wire logic SUPPLY_MONITOR_IN,
  input wire logic AUTO_WAKEUP_IN,
  // Core interrupt requests and wake event
  output logic LOW_LINES_IRQ,
  output logic SUPPLY_MONITOR_IRQ,
  output logic AUTO_WAKEUP_IRQ,
  output logic WAKE_EVENT
);
  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  logic [ELC_LINES-1:0] irq_en_r;
  logic [ELC_LINES-1:0] evt_en_r;
  logic [ELC_LINES-1:0] rise_r;
  logic [ELC_LINES-1:0] fall_r;
  logic [ELC_LINES-1:0] swtrig_r;
  logic [ELC_LINES-1:0] pend_r;
  logic [ELC_LINES-1:0] pend_nxt;
  logic [15:0] portsel_r;
  logic [2:0] core_r;
  logic [ELC_DW-1:0] rdata_r;
  logic low_irq_r;
  logic sup_irq_r;
  logic awu_irq_r;
  logic wake_r;

  // ----------------------------------------------------------------
  // Elaboration checks
  // ----------------------------------------------------------------
  // Refuse a synchroniser that cannot settle a pin change
  if (SYNC_STAGES < 3)
  begin : g_bad_sync
    $error("elc_top needs at least three synchroniser stages");
  end
  // Eight pin lines plus the two event lines
  if (ELC_LINES != ELC_PIN_LINES + 2)
  begin : g_bad_lines
    $error("elc_top line count is inconsistent");
  end
  // Event lines sit right above the pin lines
  if (ELC_LINE_SUPPLY != ELC_PIN_LINES || ELC_LINE_WAKE != ELC_LINES - 1)
  begin : g_bad_map
    $error("elc_top event line positions are inconsistent");
  end
  // Port select needs two bits per pin line inside the data word
  if (ELC_DW < 2 * ELC_PIN_LINES)
  begin : g_bad_width
    $error("elc_top data word too narrow for the port select register");
  end

  // ----------------------------------------------------------------
  // Decode
  // ----------------------------------------------------------------
  wire logic wr_irq_en = REG_WR && (REG_ADDR == ELC_OFS_IRQ_EN);
  wire logic wr_evt_en = REG_WR && (REG_ADDR == ELC_OFS_EVT_EN);
  wire logic wr_rise = REG_WR && (REG_ADDR == ELC_OFS_RISE);
  wire logic wr_fall = REG_WR && (REG_ADDR == ELC_OFS_FALL);
  wire logic wr_swtrig = REG_WR && (REG_ADDR == ELC_OFS_SWTRIG);
  wire logic wr_pend = REG_WR && (REG_ADDR == ELC_OFS_PEND);
  wire logic wr_portsel = REG_WR && (REG_ADDR == ELC_OFS_PORTSEL);
  wire logic wr_core = REG_WR && (REG_ADDR == ELC_OFS_CORE);
  wire logic [ELC_LINES-1:0] wdata_lines = REG_WDATA[ELC_LINES-1:0];

  // ----------------------------------------------------------------
  // Line sources and edge detection
  // ----------------------------------------------------------------
  wire logic [ELC_LINES-1:0] line_src;
  wire logic [ELC_LINES-1:0] hw_edge;
  wire logic sev_on_pend = core_r[ELC_CORE_SEND_EVENT_ON_PENDING_BIT];
  wire logic core_mask_low = core_r[ELC_CORE_MASK_LOW_BIT];
  wire logic core_mask_sup = core_r[ELC_CORE_MASK_SUP_BIT];

  genvar gi;
  generate
    for (gi = 0; gi < ELC_LINES; gi++)
    begin : g_line
      if (gi < ELC_PIN_LINES)
      begin : g_pin
        // Port choice per line: 0 = A, 1 = C, 2 = D, 3 reads as D
        wire logic [1:0] sel = portsel_r[2*gi+1:2*gi];
        assign line_src[gi] = (sel == 2'h0) ? PORT_A_PINS[gi] :
                              (sel == 2'h1) ? PORT_C_PINS[gi] : PORT_D_PINS[gi];
      end
      else if (gi == ELC_LINE_SUPPLY)
      begin : g_sup
        assign line_src[gi] = SUPPLY_MONITOR_IN;
      end
      else
      begin : g_awu
        assign line_src[gi] = AUTO_WAKEUP_IN;
      end
      // Synchronise then detect the selected edges
      elc_sync_edge #(
        .STAGES(SYNC_STAGES)
      ) u_edge (
        .clk(CLK),
        .arst_n(ARST_N),
        .line_in(line_src[gi]),
        .rise_en(rise_r[gi]),
        .fall_en(fall_r[gi]),
        .edge_hit(hw_edge[gi])
      );
    end
  endgenerate

  // ----------------------------------------------------------------
  // Trigger merge and gating
  // ----------------------------------------------------------------
  // Software trigger write fires the line as an edge would
  wire logic [ELC_LINES-1:0] sw_fire = wr_swtrig ? wdata_lines : '0;
  wire logic [ELC_LINES-1:0] trig = hw_edge | sw_fire;
  wire logic [ELC_LINES-1:0] trig_irq = trig & irq_en_r;
  wire logic [ELC_LINES-1:0] trig_evt = trig & evt_en_r;

  // ----------------------------------------------------------------
  // Pending flags and requests
  // ----------------------------------------------------------------
  // Pending: set wins over a write-one clear in the same cycle
  always_comb
  begin
    pend_nxt = pend_r;
    if (wr_pend)
      pend_nxt = pend_nxt & ~wdata_lines;
    pend_nxt = pend_nxt | trig_irq;
  end

  // Requests to core follow pending and enable
  wire logic low_irq_nxt = |pend_nxt[ELC_PIN_LINES-1:0] & |irq_en_r[ELC_PIN_LINES-1:0]
                           & |(pend_nxt[ELC_PIN_LINES-1:0] & irq_en_r[ELC_PIN_LINES-1:0]);
  wire logic sup_irq_nxt = pend_nxt[ELC_LINE_SUPPLY] & irq_en_r[ELC_LINE_SUPPLY];
  wire logic awu_irq_nxt = pend_nxt[ELC_LINE_WAKE] & irq_en_r[ELC_LINE_WAKE];

  // ----------------------------------------------------------------
  // Wake event
  // ----------------------------------------------------------------
  // Wake on event channel, or on a new interrupt masked in core with send-on-pending
  wire logic masked_pend_new = sev_on_pend &
                               ((core_mask_low & |trig_irq[ELC_PIN_LINES-1:0]) |
                                (core_mask_sup & trig_irq[ELC_LINE_SUPPLY]));
  wire logic wake_nxt = |trig_evt | masked_pend_new;

  // ----------------------------------------------------------------
  // Read mux
  // ----------------------------------------------------------------
  // One select per mapped register; an unmapped address selects none
  wire logic rs_irq_en = (REG_ADDR == ELC_OFS_IRQ_EN);
  wire logic rs_evt_en = (REG_ADDR == ELC_OFS_EVT_EN);
  wire logic rs_rise = (REG_ADDR == ELC_OFS_RISE);
  wire logic rs_fall = (REG_ADDR == ELC_OFS_FALL);
  wire logic rs_swtrig = (REG_ADDR == ELC_OFS_SWTRIG);
  wire logic rs_pend = (REG_ADDR == ELC_OFS_PEND);
  wire logic rs_portsel = (REG_ADDR == ELC_OFS_PORTSEL);
  wire logic rs_core = (REG_ADDR == ELC_OFS_CORE);
  // Line-wide registers merged under their selects
  wire logic [ELC_LINES-1:0] rd_lines = ({ELC_LINES{rs_irq_en}} & irq_en_r)
                                      | ({ELC_LINES{rs_evt_en}} & evt_en_r)
                                      | ({ELC_LINES{rs_rise}} & rise_r)
                                      | ({ELC_LINES{rs_fall}} & fall_r)
                                      | ({ELC_LINES{rs_swtrig}} & swtrig_r)
                                      | ({ELC_LINES{rs_pend}} & pend_r);
  wire logic [15:0] rd_portsel = {16{rs_portsel}} & portsel_r;
  wire logic [2:0] rd_core = {3{rs_core}} & core_r;
  // Each part widened to the data word on purpose, zero above its field
  wire logic [ELC_DW-1:0] rd_mux = {{(ELC_DW-ELC_LINES){1'b0}}, rd_lines}
                                 | {{(ELC_DW-16){1'b0}}, rd_portsel}
                                 | {{(ELC_DW-3){1'b0}}, rd_core};

  // ----------------------------------------------------------------
  // Configuration registers
  // ----------------------------------------------------------------
  // Interrupt enables, written only through the register port
  always_ff @(posedge CLK or negedge ARST_N)
  begin
    if (!ARST_N)
      irq_en_r <= ELC_RST_LINES;
    else if (wr_irq_en)
      irq_en_r <= wdata_lines;
  end

  // Event enables
  always_ff @(posedge CLK or negedge ARST_N)
  begin
    if (!ARST_N)
      evt_en_r <= ELC_RST_LINES;
    else if (wr_evt_en)
      evt_en_r <= wdata_lines;
  end

  // Rising edge selects
  always_ff @(posedge CLK or negedge ARST_N)
  begin
    if (!ARST_N)
      rise_r <= ELC_RST_LINES;
    else if (wr_rise)
      rise_r <= wdata_lines;
  end

  // Falling edge selects
  always_ff @(posedge CLK or negedge ARST_N)
  begin
    if (!ARST_N)
      fall_r <= ELC_RST_LINES;
    else if (wr_fall)
      fall_r <= wdata_lines;
  end

  // Port choice of the eight pin lines
  always_ff @(posedge CLK or negedge ARST_N)
  begin
    if (!ARST_N)
      portsel_r <= ELC_RST_PORTSEL;
    else if (wr_portsel)
      portsel_r <= REG_WDATA[15:0];
  end

  // Mirror of the core's send-on-pending and vector masks
  always_ff @(posedge CLK or negedge ARST_N)
  begin
    if (!ARST_N)
      core_r <= ELC_RST_CORE;
    else if (wr_core)
      core_r <= REG_WDATA[2:0];
  end

  // ----------------------------------------------------------------
  // Software trigger
  // ----------------------------------------------------------------
  // Software trigger bits clear with the pending flag
  always_ff @(posedge CLK or negedge ARST_N)
  begin
    if (!ARST_N)
      swtrig_r <= ELC_RST_LINES;
    else
      swtrig_r <= (swtrig_r | sw_fire) & ~(wr_pend ? wdata_lines : '0);
  end

  // ----------------------------------------------------------------
  // Status and read data
  // ----------------------------------------------------------------
  // Pending flags
  always_ff @(posedge CLK or negedge ARST_N)
  begin
    if (!ARST_N)
      pend_r <= ELC_RST_LINES;
    else
      pend_r <= pend_nxt;
  end

  // Read data stands one cycle after the strobe, zero otherwise
  always_ff @(posedge CLK or negedge ARST_N)
  begin
    if (!ARST_N)
      rdata_r <= '0;
    else
      rdata_r <= REG_RD ? rd_mux : '0;
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  // Merged request of lines zero to seven
  always_ff @(posedge CLK or negedge ARST_N)
  begin
    if (!ARST_N)
      low_irq_r <= 1'b0;
    else
      low_irq_r <= low_irq_nxt;
  end

  // Supply monitor request
  always_ff @(posedge CLK or negedge ARST_N)
  begin
    if (!ARST_N)
      sup_irq_r <= 1'b0;
    else
      sup_irq_r <= sup_irq_nxt;
  end

  // Auto-wakeup request
  always_ff @(posedge CLK or negedge ARST_N)
  begin
    if (!ARST_N)
      awu_irq_r <= 1'b0;
    else
      awu_irq_r <= awu_irq_nxt;
  end

  // One-cycle wake pulse per trigger cycle
  always_ff @(posedge CLK or negedge ARST_N)
  begin
    if (!ARST_N)
      wake_r <= 1'b0;
    else
      wake_r <= wake_nxt;
  end

  assign REG_RDATA = rdata_r;
  assign LOW_LINES_IRQ = low_irq_r;
  assign SUPPLY_MONITOR_IRQ = sup_irq_r;
  assign AUTO_WAKEUP_IRQ = awu_irq_r;
  assign WAKE_EVENT = wake_r;
endmodule

//--- testbench/elc_core_model.sv
// Core side model: latches requests as pending bits and counts wake pulses.
// Assumes requests and the wake event are synchronous to the clock.
`timescale 1ns/1ps
module elc_core_model
(
  // Clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // Requests and software clear
  input wire logic [2:0] irq,
  input wire logic wake,
  input wire logic [2:0] clr,
  // State seen by the bench
  output logic [2:0] pend_r,
  output int wake_cnt
);
  // Pending bits stay until software clears them
  always @(posedge clk or negedge arst_n)
    if (!arst_n)
    begin
      pend_r <= 3'h0;
      wake_cnt <= 0;
    end
    else
    begin
      pend_r <= (pend_r | irq) & ~clr;
      wake_cnt <= wake_cnt + int'(wake);
    end
endmodule

//--- testbench/elc_props.sv
// Checker for the external line event controller register port and requests.
// Assumes one clock domain and the register map of the package.
`timescale 1ns/1ps
module elc_props
  import elc_pkg::*;
(
  // Clock and reset
  input wire logic CLK,
  input wire logic ARST_N,
  // Register port
  input wire logic [ELC_AW-1:0] REG_ADDR,
  input wire logic [ELC_DW-1:0] REG_WDATA,
  input wire logic REG_WR,
  input wire logic REG_RD,
  input wire logic [ELC_DW-1:0] REG_RDATA,
  // Core requests
  input wire logic LOW_LINES_IRQ,
  input wire logic SUPPLY_MONITOR_IRQ,
  input wire logic WAKE_EVENT
);
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!ARST_N);
  logic [9:0] ie_r;
  logic [9:0] ee_r;
  // Write decodes
  wire ie_wr = REG_WR && REG_ADDR == ELC_OFS_IRQ_EN;
  wire ee_wr = REG_WR && REG_ADDR == ELC_OFS_EVT_EN;
  wire sw_wr = REG_WR && REG_ADDR == ELC_OFS_SWTRIG;
  wire clr_wr = ie_wr || (REG_WR && REG_ADDR == ELC_OFS_PEND);
  // Shadow of both enable registers
  always_ff @(posedge CLK or negedge ARST_N)
    if (!ARST_N)
    begin
      ie_r <= 10'h000;
      ee_r <= 10'h000;
    end
    else
    begin
      if (ie_wr) ie_r <= REG_WDATA[9:0];
      if (ee_wr) ee_r <= REG_WDATA[9:0];
    end
  chk_rdata_idle: assert property (!$past(REG_RD) |-> REG_RDATA == 32'h0)
    else $error("read data not zero outside read cycle");
  chk_unmapped_read: assert property (REG_RD && REG_ADDR > ELC_OFS_CORE |=> REG_RDATA == 32'h0)
    else $error("unmapped read not zero");
  chk_reserved_bits: assert property (REG_RD && REG_ADDR != ELC_OFS_PORTSEL |=> REG_RDATA[31:10] == 22'h0)
    else $error("reserved bits not zero");
  chk_ie_readback: assert property (ie_wr ##1 (REG_RD && REG_ADDR == ELC_OFS_IRQ_EN)
    |=> REG_RDATA[9:0] == $past(REG_WDATA[9:0], 2)) else $error("irq enable readback wrong");
  chk_ee_readback: assert property (ee_wr ##1 (REG_RD && REG_ADDR == ELC_OFS_EVT_EN)
    |=> REG_RDATA[9:0] == $past(REG_WDATA[9:0], 2)) else $error("event enable readback wrong");
  chk_sw_low_irq: assert property (sw_wr && |(REG_WDATA[7:0] & ie_r[7:0]) |-> ##2 LOW_LINES_IRQ)
    else $error("software trigger gave no low lines request");
  chk_sw_supply: assert property (sw_wr && REG_WDATA[8] && ie_r[8] |-> ##2 SUPPLY_MONITOR_IRQ)
    else $error("software trigger gave no supply request");
  chk_sw_wake: assert property (sw_wr && |(REG_WDATA[9:0] & ee_r) |-> ##1 WAKE_EVENT)
    else $error("event enabled trigger gave no wake pulse");
  chk_irq_hold: assert property (LOW_LINES_IRQ && !clr_wr && !$past(clr_wr) |=> LOW_LINES_IRQ)
    else $error("request dropped while pending");
endmodule
bind elc_top elc_props u_props (.CLK(CLK), .ARST_N(ARST_N), .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA),
  .REG_WR(REG_WR), .REG_RD(REG_RD), .REG_RDATA(REG_RDATA), .LOW_LINES_IRQ(LOW_LINES_IRQ),
  .SUPPLY_MONITOR_IRQ(SUPPLY_MONITOR_IRQ), .WAKE_EVENT(WAKE_EVENT));

//--- testbench/elc_top_tb.sv
// Bench for the external line event controller with a core model.
// Assumes the checker binds itself to the top module.
`timescale 1ns/1ps
module elc_top_tb;
  import elc_pkg::*;
  logic clk = 1'b0, arst_n = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0, sup_in = 1'b0, wak_in = 1'b0;
  logic [7:0] reg_addr = 8'h00, pa = 8'h00, pc = 8'h00, pd = 8'h00;
  logic [31:0] reg_wdata = 32'h0, reg_rdata;
  logic [2:0] core_clr = 3'h0, core_pend;
  logic low_irq, sup_irq, wak_irq, wake;
  int wake_cnt, w0, sel, err_total = 0, num_checks = 0;
  elc_top DUT (.CLK(clk), .ARST_N(arst_n), .REG_ADDR(reg_addr), .REG_WDATA(reg_wdata), .REG_WR(reg_wr),
    .REG_RD(reg_rd), .REG_RDATA(reg_rdata), .PORT_A_PINS(pa), .PORT_C_PINS(pc), .PORT_D_PINS(pd),
    .SUPPLY_MONITOR_IN(sup_in), .AUTO_WAKEUP_IN(wak_in), .LOW_LINES_IRQ(low_irq),
    .SUPPLY_MONITOR_IRQ(sup_irq), .AUTO_WAKEUP_IRQ(wak_irq), .WAKE_EVENT(wake));
  elc_core_model u_core (.clk(clk), .arst_n(arst_n), .irq({wak_irq, sup_irq, low_irq}), .wake(wake),
    .clr(core_clr), .pend_r(core_pend), .wake_cnt(wake_cnt));
  // Clock and watchdog
  initial forever #12.5 clk = ~clk;
  initial
  begin
    #(25 * 20000);
    err_total++;
    end_sim();
  end
  // Bus cycles and compare
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    num_checks++;
    if (g !== e) begin err_total++; $display("[ERR] %s expected %h seen %h", n, e, g); end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk) {reg_addr, reg_wdata, reg_wr} <= {a, d, 1'b1};
    @(posedge clk) reg_wr <= 1'b0;
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] e, input logic wfirst);
    @(posedge clk) {reg_addr, reg_wdata, reg_wr, reg_rd} <= {a, e, wfirst, ~wfirst};
    if (wfirst) @(posedge clk) {reg_wr, reg_rd} <= 2'b01;
    @(posedge clk) reg_rd <= 1'b0;
    #1;
    chk("rdata", e & 32'h3FF, reg_rdata);
  endtask
  // Drive line source: selected port gets v, the others the inverse
  task automatic src(input int l, input int s, input logic v);
    @(posedge clk);
    if (l == 8) sup_in <= v;
    else if (l == 9) wak_in <= v;
    else begin pa[l] <= (s == 0) ? v : ~v; pc[l] <= (s == 1) ? v : ~v; pd[l] <= (s >= 2) ? v : ~v; end
  endtask
  task automatic end_sim;
    $display("checks %0d mismatches %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  // Main sequence
  initial
  begin
    void'($urandom(32'h364B));
    repeat (12) @(posedge clk);
    arst_n <= 1'b1;
    rdc(ELC_OFS_IRQ_EN, 0, 0);
    rdc(ELC_OFS_EVT_EN, 0, 0);
    w0 = $urandom;
    rdc(ELC_OFS_IRQ_EN, w0, 1);
    rdc(ELC_OFS_EVT_EN, ~w0, 1);
    wr(8'h40, w0);
    rdc(8'h40, 0, 0);
    $display("test registers done");
    wr(ELC_OFS_IRQ_EN, 'h3FF);
    wr(ELC_OFS_EVT_EN, 0);
    for (int l = 0; l < 10; l++)
    begin
      wr(ELC_OFS_SWTRIG, 1 << l);
      repeat (2) @(posedge clk);
      #1;
      chk("low_irq", l < 8, low_irq);
      chk("sup_irq", l == 8, sup_irq);
      chk("wak_irq", l == 9, wak_irq);
      wr(ELC_OFS_PEND, 0);
      rdc(ELC_OFS_PEND, 1 << l, 0);
      wr(ELC_OFS_PEND, 1 << l);
      rdc(ELC_OFS_PEND, 0, 0);
    end
    chk("wake_cnt", 0, wake_cnt);
    chk("core_pend", 3'h7, core_pend);
    @(posedge clk) core_clr <= 3'h7;
    @(posedge clk) core_clr <= 3'h0;
    #1;
    chk("core_pend", 0, core_pend);
    $display("test software trigger done");
    wr(ELC_OFS_IRQ_EN, 0);
    wr(ELC_OFS_EVT_EN, 'h3FF);
    for (int l = 0; l < 10; l++)
    begin
      wr(ELC_OFS_SWTRIG, 1 << l);
      rdc(ELC_OFS_PEND, 0, 0);
      wr(ELC_OFS_PEND, 'h3FF);
    end
    chk("wake_cnt", 10, wake_cnt);
    wr(ELC_OFS_EVT_EN, 0);
    wr(ELC_OFS_IRQ_EN, 'h101);
    for (int c = 0; c < 8; c++)
    begin
      w0 = wake_cnt;
      wr(ELC_OFS_CORE, c);
      wr(ELC_OFS_SWTRIG, 'h101);
      repeat (3) @(posedge clk);
      chk("wake_cnt", w0 + ((c & 1) && (c & 6)), wake_cnt);
      wr(ELC_OFS_PEND, 'h101);
    end
    $display("test events done");
    wr(ELC_OFS_IRQ_EN, 'h3FF);
    wr(ELC_OFS_SWTRIG, 'h3FF);
    @(posedge clk) arst_n <= 1'b0;
    repeat (3) @(posedge clk);
    arst_n <= 1'b1;
    #1;
    chk("low_irq", 0, low_irq);
    rdc(ELC_OFS_PEND, 0, 0);
    rdc(ELC_OFS_IRQ_EN, 0, 0);
    $display("test mid-run reset done");
    wr(ELC_OFS_IRQ_EN, 'h3FF);
    for (int m = 1; m < 4; m++)
    begin
      wr(ELC_OFS_RISE, (m & 1) ? 'h3FF : 0);
      wr(ELC_OFS_FALL, (m & 2) ? 'h3FF : 0);
      for (int l = 0; l < 10; l++)
      begin
        sel = $urandom_range(3, 0);
        wr(ELC_OFS_PORTSEL, sel * 'h5555);
        src(l, sel, 0);
        repeat (8) @(posedge clk);
        wr(ELC_OFS_PEND, 'h3FF);
        src(l, sel, 1);
        repeat (8) @(posedge clk);
        rdc(ELC_OFS_PEND, (m & 1) << l, 0);
        wr(ELC_OFS_PEND, 'h3FF);
        src(l, sel, 0);
        repeat (8) @(posedge clk);
        rdc(ELC_OFS_PEND, (m >> 1) << l, 0);
      end
    end
    $display("test pin edges done");
    end_sim();
  end
endmodule
